// [core/pma_regs_pkg.sv]
package pma_regs_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [15:0] IDX_QUALITY = 16'h0871;
	localparam logic [15:0] IDX_CONTROL = 16'h1000;
	localparam logic [15:0] IDX_LINK = 16'h1001;
	localparam logic [15:0] IDX_TYPE = 16'h1007;
	localparam logic [15:0] IDX_EXT_ABILITY = 16'h100b;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int SQ_W = 3;
	// field positions
	localparam int WORST_LSB = 5;
	localparam int CURRENT_LSB = 1;
	localparam int RESET_BIT = 15;
	localparam int LOOPBACK_BIT = 0;
	localparam int LINK_BIT = 2;
	localparam int EXT_BIT = 11;
	// reset and fixed values
	localparam logic [SQ_W-1:0] SQ_RESET = 3'h0;
	localparam logic [5:0] MEDIUM_TYPE_CODE = 6'h3d;
	localparam logic [REG_W-1:0] CONTROL_RESET = 16'h0000;
	localparam logic [REG_W-1:0] EXT_ABILITY_VALUE = 16'h0800;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
	localparam logic [1:0] BYTE_SHIFT = 2'h2;
	localparam logic [2:0] DSTATE_RESET = 3'h1;
endpackage

// [core/quality_tracker.sv]
`timescale 1ns/10ps
module quality_tracker
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [pma_regs_pkg::SQ_W-1:0] quality_level,
	input wire logic read_strobe,
	output logic [pma_regs_pkg::SQ_W-1:0] current_quality,
	output logic [pma_regs_pkg::SQ_W-1:0] worst_quality
);
	logic [pma_regs_pkg::SQ_W-1:0] next_current_quality;
	logic [pma_regs_pkg::SQ_W-1:0] next_worst_quality;

	// lower level means poorer signal quality
	function automatic logic [pma_regs_pkg::SQ_W-1:0] poorer(
		input logic [pma_regs_pkg::SQ_W-1:0] a,
		input logic [pma_regs_pkg::SQ_W-1:0] b);
		poorer = (a < b) ? a : b;
	endfunction

	always_comb
	begin
		next_current_quality = quality_level;
		if (read_strobe)
			next_worst_quality = quality_level;
		else
			next_worst_quality = poorer(worst_quality, quality_level);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			current_quality <= pma_regs_pkg::SQ_RESET;
			worst_quality <= pma_regs_pkg::SQ_RESET;
		end
		else
		begin
			current_quality <= next_current_quality;
			worst_quality <= next_worst_quality;
		end
	end

	property p_worst_not_above_current;
		@(posedge pclk) disable iff (!presetn)
		!$past(read_strobe) |-> worst_quality <= current_quality;
	endproperty
	a_worst_not_above_current: assert property (p_worst_not_above_current)
		else $error("worst quality above current");

	property p_restart_after_read;
		@(posedge pclk) disable iff (!presetn)
		read_strobe |=> worst_quality == $past(quality_level);
	endproperty
	a_restart_after_read: assert property (p_restart_after_read)
		else $error("worst tracking not restarted after read");

	property p_current_follows;
		@(posedge pclk) disable iff (!presetn)
		1 |=> current_quality == $past(quality_level);
	endproperty
	a_current_follows: assert property (p_current_follows)
		else $error("current quality does not follow input");
endmodule // quality_tracker

// [core/pma_quality_status_regs.sv]
`timescale 1ns/10ps
// Functional notes
// - quality register bits 7:5 give poorest quality seen since last read
// - quality register bits 3:1 give present quality level, reset zero
// - control bit 15 holds medium attachment in reset while one
// - control bit 0 enables medium attachment loopback, reset zero
// - link status bit 2 reflects link monitor, one when up
// - type register bits 5:0 return fixed code 111101b
// - extended ability bit 11 reads one
module pma_quality_status_regs
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pma_regs_pkg::ADDR_W+1:0] paddr,
	input wire logic [pma_regs_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [pma_regs_pkg::DATA_W-1:0] prdata,
	input wire logic [pma_regs_pkg::SQ_W-1:0] quality_level,
	input wire logic link_up,
	output logic medium_attach_reset,
	output logic medium_attach_loopback
);
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_ACCESS = 3'b010,
		ST_DONE = 3'b100
	} bus_state_t;

	bus_state_t bus_state;
	bus_state_t next_bus_state;
	logic [pma_regs_pkg::REG_W-1:0] control;
	logic [pma_regs_pkg::REG_W-1:0] next_control;
	logic [pma_regs_pkg::DATA_W-1:0] next_prdata;
	logic next_pslverr;
	logic quality_read;
	logic access;
	logic setup;
	logic hit;
	logic [pma_regs_pkg::REG_W-1:0] read_word;
	logic [pma_regs_pkg::SQ_W-1:0] current_quality;
	logic [pma_regs_pkg::SQ_W-1:0] worst_quality;
	logic [pma_regs_pkg::ADDR_W-1:0] index;

	////////////////////////////////////////////////////////////////////////
	// address decode; byte lanes 0 and 1 carry the 16-bit register

	function automatic logic mapped(input logic [pma_regs_pkg::ADDR_W-1:0] idx);
		mapped = (idx == pma_regs_pkg::IDX_QUALITY) || (idx == pma_regs_pkg::IDX_CONTROL)
			|| (idx == pma_regs_pkg::IDX_LINK) || (idx == pma_regs_pkg::IDX_TYPE)
			|| (idx == pma_regs_pkg::IDX_EXT_ABILITY);
	endfunction

	assign index = paddr[pma_regs_pkg::ADDR_W+1:2];
	// setup cycle of a transfer; never while the access cycle is in progress
	assign setup = psel && !penable && (bus_state != ST_ACCESS);
	assign access = psel && penable && (bus_state == ST_ACCESS);
	assign hit = mapped(index);
	// read side effect fires once, where the read word is latched
	assign quality_read = setup && !pwrite && (index == pma_regs_pkg::IDX_QUALITY);
	assign pready = (bus_state == ST_ACCESS);

	always_comb
	begin
		read_word = pma_regs_pkg::CONTROL_RESET;
		case (index)
			pma_regs_pkg::IDX_QUALITY:
			begin
				read_word[pma_regs_pkg::WORST_LSB +: pma_regs_pkg::SQ_W] = worst_quality;
				read_word[pma_regs_pkg::CURRENT_LSB +: pma_regs_pkg::SQ_W] = current_quality;
			end
			pma_regs_pkg::IDX_CONTROL:
				read_word = control;
			pma_regs_pkg::IDX_LINK:
				read_word[pma_regs_pkg::LINK_BIT] = link_up;
			pma_regs_pkg::IDX_TYPE:
				read_word[$bits(pma_regs_pkg::MEDIUM_TYPE_CODE)-1:0] =
					pma_regs_pkg::MEDIUM_TYPE_CODE;
			pma_regs_pkg::IDX_EXT_ABILITY:
				read_word = pma_regs_pkg::EXT_ABILITY_VALUE;
			default:
				read_word = pma_regs_pkg::CONTROL_RESET;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// bus state: one wait-free access cycle, pready combinational

	always_comb
	begin
		next_bus_state = bus_state;
		case (bus_state)
			ST_IDLE:
				if (psel && !penable)
					next_bus_state = ST_ACCESS;
			ST_ACCESS:
				next_bus_state = ST_DONE;
			ST_DONE:
				if (psel && !penable)
					next_bus_state = ST_ACCESS;
				else
					next_bus_state = ST_IDLE;
			default:
				next_bus_state = ST_IDLE;
		endcase
	end

	always_comb
	begin
		next_control = control;
		next_prdata = prdata;
		next_pslverr = pslverr;
		// latched in setup so data comes from flops yet needs no wait state
		if (setup)
		begin
			next_pslverr = !hit;
			if (!pwrite)
				next_prdata = hit
					? {{(pma_regs_pkg::DATA_W - pma_regs_pkg::REG_W){1'b0}}, read_word}
					: pma_regs_pkg::READ_ZERO;
		end
		if (access && pwrite && (index == pma_regs_pkg::IDX_CONTROL))
		begin
			// only writable bits; reserved bits stay zero
			if (pstrb[1])
				next_control[pma_regs_pkg::RESET_BIT] = pwdata[pma_regs_pkg::RESET_BIT];
			if (pstrb[0])
				next_control[pma_regs_pkg::LOOPBACK_BIT] =
					pwdata[pma_regs_pkg::LOOPBACK_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_state <= ST_IDLE;
			control <= pma_regs_pkg::CONTROL_RESET;
			prdata <= pma_regs_pkg::READ_ZERO;
			pslverr <= 1'b0;
		end
		else
		begin
			bus_state <= next_bus_state;
			control <= next_control;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs to the medium attachment; registered, never glitch

	assign medium_attach_reset = control[pma_regs_pkg::RESET_BIT];
	assign medium_attach_loopback = control[pma_regs_pkg::LOOPBACK_BIT];

	quality_tracker u_quality_tracker
	(
		.pclk(pclk),
		.presetn(presetn),
		.quality_level(quality_level),
		.read_strobe(quality_read),
		.current_quality(current_quality),
		.worst_quality(worst_quality)
	);

	////////////////////////////////////////////////////////////////////////
	// assertions

	property p_reset_bit_write;
		@(posedge pclk) disable iff (!presetn)
		access && pwrite && index == pma_regs_pkg::IDX_CONTROL && pstrb[1]
			|=> medium_attach_reset == $past(pwdata[pma_regs_pkg::RESET_BIT]);
	endproperty
	a_reset_bit_write: assert property (p_reset_bit_write)
		else $error("reset bit not written");

	property p_loopback_write;
		@(posedge pclk) disable iff (!presetn)
		access && pwrite && index == pma_regs_pkg::IDX_CONTROL && pstrb[0]
			|=> medium_attach_loopback == $past(pwdata[pma_regs_pkg::LOOPBACK_BIT]);
	endproperty
	a_loopback_write: assert property (p_loopback_write)
		else $error("loopback bit not written");

	property p_control_stable;
		@(posedge pclk) disable iff (!presetn)
		!(access && pwrite) |=> $stable(control);
	endproperty
	a_control_stable: assert property (p_control_stable)
		else $error("control changed without write");

	property p_link_read;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && index == pma_regs_pkg::IDX_LINK
			|=> prdata[pma_regs_pkg::LINK_BIT] == $past(link_up);
	endproperty
	a_link_read: assert property (p_link_read)
		else $error("link status read wrong");

	property p_type_read;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && index == pma_regs_pkg::IDX_TYPE
			|=> prdata == 32'h0000_003d;
	endproperty
	a_type_read: assert property (p_type_read)
		else $error("medium type code wrong");

	property p_ext_read;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && index == pma_regs_pkg::IDX_EXT_ABILITY
			|=> prdata == 32'h0000_0800;
	endproperty
	a_ext_read: assert property (p_ext_read)
		else $error("extended ability wrong");

	property p_quality_read;
		@(posedge pclk) disable iff (!presetn)
		quality_read |=> prdata[7:5] == $past(worst_quality)
			&& prdata[3:1] == $past(current_quality);
	endproperty
	a_quality_read: assert property (p_quality_read)
		else $error("quality fields read wrong");

	property p_pready_one_cycle;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && bus_state != ST_ACCESS |=> pready ##1 !pready;
	endproperty
	a_pready_one_cycle: assert property (p_pready_one_cycle)
		else $error("pready timing wrong");

	property p_pslverr_flag;
		@(posedge pclk) disable iff (!presetn)
		setup |=> pslverr == !$past(hit);
	endproperty
	a_pslverr_flag: assert property (p_pslverr_flag)
		else $error("error flag does not match decode");

	property p_quality_reserved;
		@(posedge pclk) disable iff (!presetn)
		quality_read |=> (prdata & 32'hffff_ff11) == 32'h0000_0000;
	endproperty
	a_quality_reserved: assert property (p_quality_reserved)
		else $error("quality reserved bits not zero");

	property p_link_reserved;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && index == pma_regs_pkg::IDX_LINK
			|=> (prdata & 32'hffff_fffb) == 32'h0000_0000;
	endproperty
	a_link_reserved: assert property (p_link_reserved)
		else $error("link status reserved bits not zero");

	property p_control_read;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && index == pma_regs_pkg::IDX_CONTROL
			|=> (prdata & 32'hffff_7ffe) == 32'h0000_0000
			&& prdata[pma_regs_pkg::RESET_BIT] == $past(medium_attach_reset)
			&& prdata[pma_regs_pkg::LOOPBACK_BIT] == $past(medium_attach_loopback);
	endproperty
	a_control_read: assert property (p_control_read)
		else $error("control read back wrong");

	// a write with lane 1 off must leave the reset bit alone
	property p_reset_hold;
		@(posedge pclk) disable iff (!presetn)
		!(access && pwrite && index == pma_regs_pkg::IDX_CONTROL && pstrb[1])
			|=> $stable(medium_attach_reset);
	endproperty
	a_reset_hold: assert property (p_reset_hold)
		else $error("reset bit changed without lane 1 write");

	property p_loopback_hold;
		@(posedge pclk) disable iff (!presetn)
		!(access && pwrite && index == pma_regs_pkg::IDX_CONTROL && pstrb[0])
			|=> $stable(medium_attach_loopback);
	endproperty
	a_loopback_hold: assert property (p_loopback_hold)
		else $error("loopback bit changed without lane 0 write");

	property p_write_keeps_read_data;
		@(posedge pclk) disable iff (!presetn)
		setup && pwrite |=> $stable(prdata);
	endproperty
	a_write_keeps_read_data: assert property (p_write_keeps_read_data)
		else $error("read data disturbed by write");

	property p_unmapped_read_zero;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && !hit |=> prdata == 32'h0000_0000;
	endproperty
	a_unmapped_read_zero: assert property (p_unmapped_read_zero)
		else $error("unmapped read not zero");

	c_quality_read: cover property (@(posedge pclk) disable iff (!presetn) quality_read);
	c_link_up_read: cover property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && index == pma_regs_pkg::IDX_LINK && link_up);
	c_loopback_on: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(medium_attach_loopback));
	c_reset_on: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(medium_attach_reset));
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) access && !hit);
endmodule // pma_quality_status_regs

// [dv/tb_pma_quality_status_regs.sv]
`timescale 1ns/10ps
module tb_pma_quality_status_regs;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h0;
	logic pready;
	logic pslverr;
	logic [31:0] prdata;
	logic [2:0] quality_level = 3'h0;
	logic link_up = 1'b0;
	logic medium_attach_reset;
	logic medium_attach_loopback;
	int err_total = 0;
	int checked = 0;
	logic [31:0] rd;
	logic err;
	logic [3:0] wr_strb = 4'hf;
	int worst_m;
	int cur_m;
	int lvl;

	always #50 pclk = ~pclk;

	pma_quality_status_regs DUT
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.quality_level(quality_level),
		.link_up(link_up),
		.medium_attach_reset(medium_attach_reset),
		.medium_attach_loopback(medium_attach_loopback)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one apb transfer; only the watchdog bounds the wait for pready
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		pstrb <= wr ? wr_strb : 4'h0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		// taken at the edge where pready is seen high, before release
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp,
		input logic exp_err);
		apb(1'b0, idx, 32'h00000000);
		check(what, rd, exp);
		check("error flag", {31'h0, err}, {31'h0, exp_err});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2000) @(posedge pclk);
		err_total++;
		tally_and_finish();
	end

	initial
	begin
		void'($urandom(32'hf0e7));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("quality", pma_regs_pkg::IDX_QUALITY, 32'h0, 1'b0);
		rd_chk("control", pma_regs_pkg::IDX_CONTROL, 32'h0, 1'b0);
		rd_chk("link", pma_regs_pkg::IDX_LINK, 32'h0, 1'b0);
		rd_chk("type", pma_regs_pkg::IDX_TYPE, 32'h3d, 1'b0);
		rd_chk("ext", pma_regs_pkg::IDX_EXT_ABILITY, 32'h800, 1'b0);
		rd_chk("unmapped", 16'h1002, 32'h0, 1'b1);
		// reserved control bits must drop out
		apb(1'b1, pma_regs_pkg::IDX_CONTROL, 32'h0000ffff);
		@(negedge pclk);
		check("reset out", {31'h0, medium_attach_reset}, 32'h1);
		check("loop out", {31'h0, medium_attach_loopback}, 32'h1);
		rd_chk("control", pma_regs_pkg::IDX_CONTROL, 32'h8001, 1'b0);
		apb(1'b1, pma_regs_pkg::IDX_CONTROL, 32'h00000001);
		@(negedge pclk);
		check("reset out", {31'h0, medium_attach_reset}, 32'h0);
		check("loop out", {31'h0, medium_attach_loopback}, 32'h1);
		apb(1'b1, pma_regs_pkg::IDX_CONTROL, 32'h00000000);
		@(negedge pclk);
		check("loop out", {31'h0, medium_attach_loopback}, 32'h0);
		// byte strobes gate each control bit on its own lane
		wr_strb = 4'h1;
		apb(1'b1, pma_regs_pkg::IDX_CONTROL, 32'h00008001);
		@(negedge pclk);
		check("reset out", {31'h0, medium_attach_reset}, 32'h0);
		check("loop out", {31'h0, medium_attach_loopback}, 32'h1);
		wr_strb = 4'h2;
		apb(1'b1, pma_regs_pkg::IDX_CONTROL, 32'h00008000);
		@(negedge pclk);
		check("reset out", {31'h0, medium_attach_reset}, 32'h1);
		check("loop out", {31'h0, medium_attach_loopback}, 32'h1);
		wr_strb = 4'hf;
		apb(1'b1, pma_regs_pkg::IDX_TYPE, 32'h00000000);
		rd_chk("type", pma_regs_pkg::IDX_TYPE, 32'h3d, 1'b0);
		apb(1'b1, pma_regs_pkg::IDX_EXT_ABILITY, 32'h00000000);
		rd_chk("ext", pma_regs_pkg::IDX_EXT_ABILITY, 32'h800, 1'b0);
		@(posedge pclk);
		link_up <= 1'b1;
		rd_chk("link", pma_regs_pkg::IDX_LINK, 32'h4, 1'b0);
		@(posedge pclk);
		link_up <= 1'b0;
		rd_chk("link", pma_regs_pkg::IDX_LINK, 32'h0, 1'b0);
		// levels held several clocks so one-clock sampling lag never matters
		worst_m = 0;
		cur_m = 0;
		for (int i = 0; i < 12; i++)
		begin
			for (int k = 0; k < 3; k++)
			begin
				@(posedge pclk);
				lvl = $urandom_range(7);
				quality_level <= lvl[2:0];
				worst_m = (lvl < worst_m) ? lvl : worst_m;
				cur_m = lvl;
				repeat (2) @(posedge pclk);
			end
			rd_chk("quality", pma_regs_pkg::IDX_QUALITY, 32'((worst_m << 5) | (cur_m << 1)),
				1'b0);
			worst_m = cur_m;
		end
		rd_chk("quality", pma_regs_pkg::IDX_QUALITY, 32'((cur_m << 5) | (cur_m << 1)),
			1'b0);
		tally_and_finish();
	end
endmodule // tb_pma_quality_status_regs
